/* core/sleep_wake_controller.v */
// Sleep entry, wake sequencing, sleep timer and watchdog
// What this block does
// - Sleep bit write alone enters standby sleep
// - Bus or USB enable adds bus-wake power
// - Sleeping bus logic matches 7-bit address, interrupts
// - Sleep mid-transfer aborts transfer, answers NACK
// - Deep sleep powers down the slow oscillator
// - Crystal without presence stops slow clock
// - Standby wakes on timer, GPIO, timer0, USB
// - Bus-wake mode also wakes on address match
// - Deep sleep wakes only on GPIO or USB
// - Low supply during buzz wakes from standby
// - Watchdog in sleep wakes first, then resets
// - Sleep bit clear starts tapped wake sequence
// - Power-good phase lasts three slow oscillator ticks
// - Sleep timer is 15-bit slow clock counter
// - Timer halts in deep sleep, debug stop
// - Periodic sleep interrupt at selected interval
// - Resets and code 38h zero the timer
// - Enabled pending interrupt blocks sleep bit set
// - Wake uses masks only, not global enable
// - Pending interrupt keeps clearing sleep bit
// - Prefetched instruction runs before service routine
// - No interrupt right after global enable
// - Watchdog fires after three timer rollovers
// - Double taps bit doubles each tap phase, not power-good
`timescale 1ns/10ps
`include "sleep_wake_map.vh"
module sleep_wake_controller #(
    parameter ILO_DIV = `ILO_DIV
) (
    input wire i_ref_clk,
    input wire i_rst,
    input wire i_sleep_wr,
    input wire i_bus_wake_en,
    input wire i_usb_en,
    input wire i_crystal_on,
    input wire i_crystal_exists,
    input wire i_slow_osc_off,
    input wire i_crystal_tick,
    input wire [1:0] i_interval_sel,
    input wire [6:0] i_wake_tap_cfg,
    input wire i_debug_mode,
    input wire i_cpu_stop,
    input wire i_wdt_clear_wr,
    input wire [7:0] i_wdt_clear_data,
    input wire [5:0] i_irq_mask,
    input wire i_gpio_irq,
    input wire i_timer0_irq,
    input wire i_usb_irq,
    input wire i_buzz,
    input wire i_supply_low,
    input wire i_sleep_irq_clr,
    input wire i_i2c_irq_clr,
    input wire i_lvd_irq_clr,
    input wire i_gie,
    input wire i_gie_set,
    input wire i_instr_end,
    input wire i_scl,
    input wire i_sda,
    input wire [6:0] i_own_addr,
    output wire o_sleep_req,
    output wire o_bus_wake_power,
    output wire o_slow_osc_pd,
    output wire o_slow_clock_run,
    output wire o_wake_busy,
    output wire [14:0] o_sleep_timer,
    output wire [5:0] o_irq_pending,
    output wire o_irq_take,
    output reg o_resume,
    output reg o_wdt_reset,
    output wire o_sda_out,
    output wire o_sda_oe
);
    localparam [2:0] S_AWAKE = 3'h0;
    localparam [2:0] S_ASLEEP = 3'h1;
    localparam [2:0] S_PGOOD = 3'h2;
    localparam [2:0] S_PH0 = 3'h3;
    localparam [2:0] S_PH1 = 3'h4;
    localparam [2:0] S_PH2 = 3'h5;
    localparam [2:0] S_RESUME = 3'h6;
    localparam [31:0] PG_LAST = `PGOOD_TICKS - 1;
    localparam [31:0] WDT_LAST = `WDT_ROLLS - 1;

    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    reg sleep_ff;
    reg [1:0] mode_ff;
    reg [8:0] ilo_ff;
    reg [14:0] timer_ff;
    reg [1:0] wdt_ff;
    reg wdt_wait_ff;
    reg [5:0] pend_ff;
    reg hold_ff;
    reg [1:0] pg_ff;
    reg [10:0] ph_ff;
    reg [10:0] nxt_ph;
    reg [14:0] ivl_mask;
    reg [5:0] allow;
    wire i2c_match;

    // Tap table in microseconds, scaled to clock cycles, less one
    function [10:0] tap_load;
        input [1:0] phase;
        input [1:0] sel;
        input dbl;
        reg [31:0] us;
        reg [31:0] cycles;
        begin
            us = 32'h00000000;
            case ({phase, sel})
                4'h0: us = `T0_US_0;
                4'h1: us = `T0_US_1;
                4'h2: us = `T0_US_2;
                4'h3: us = `T0_US_3;
                4'h4: us = `T1_US_0;
                4'h5: us = `T1_US_1;
                4'h6: us = `T1_US_2;
                4'h7: us = `T1_US_3;
                4'h8: us = `T2_US_0;
                4'h9: us = `T2_US_1;
                4'hA: us = `T2_US_2;
                default: us = `T2_US_3;
            endcase
            // Longest tap is 600 cycles, so 11 bits always hold it
            cycles = (us * `CLK_MHZ) << dbl;
            tap_load = cycles[10:0] - 11'h001;
        end
    endfunction

    wire dbl = i_wake_tap_cfg[`CFG_DBL];
    wire asleep = (state_ff == S_ASLEEP);
    wire deep_now = asleep & (mode_ff == `MODE_DEEP);
    wire want_deep = ~i_bus_wake_en & ~i_usb_en & ~i_crystal_on &
        i_slow_osc_off;
    wire want_bus = i_bus_wake_en | i_usb_en;
    wire xtal_sel = i_crystal_on & i_crystal_exists;
    wire clk_stop = i_crystal_on & ~i_crystal_exists;

    // Slow oscillator is a divider; it is gated off only in deep sleep
    wire ilo_tick = ~deep_now && (ilo_ff == ILO_DIV - 1);
    wire slow_tick = clk_stop ? 1'b0 :
        (xtal_sel ? i_crystal_tick : ilo_tick);
    wire st_en = slow_tick & ~deep_now &
        ~(i_debug_mode & i_cpu_stop);
    wire [14:0] st_nxt = timer_ff + 15'h0001;
    wire roll = st_en & ((st_nxt & ivl_mask) == 15'h0000);
    wire wdt_fire = roll & (wdt_ff == WDT_LAST);
    wire clr_code = i_wdt_clear_wr &
        (i_wdt_clear_data == `WDT_CLR_TIMER);

    // Wake and sleep-entry decisions use the individual masks only
    wire [5:0] enabled = pend_ff & i_irq_mask;
    wire any_en = |enabled;
    wire wake = |(enabled & allow) | wdt_wait_ff;
    wire irq_ok = (state_ff == S_AWAKE) | (state_ff == S_RESUME);
    wire ph_zero = (ph_ff == 11'h000);

    always @* begin
        case (i_interval_sel)
            2'h0: ivl_mask = `IVL_MASK_0;
            2'h1: ivl_mask = `IVL_MASK_1;
            2'h2: ivl_mask = `IVL_MASK_2;
            default: ivl_mask = `IVL_MASK_3;
        endcase
    end

    always @* begin
        case (mode_ff)
            `MODE_BUS: allow = `WAKE_BUS;
            `MODE_DEEP: allow = `WAKE_DEEP;
            default: allow = `WAKE_STANDBY;
        endcase
    end

    always @* begin
        nxt_state = state_ff;
        nxt_ph = ph_ff;
        case (state_ff)
            S_AWAKE: begin
                if (i_sleep_wr & ~any_en) begin
                    nxt_state = S_ASLEEP;
                end
            end
            S_ASLEEP: begin
                if (wake) begin
                    nxt_state = S_PGOOD;
                end
            end
            S_PGOOD: begin
                if (ilo_tick && pg_ff == PG_LAST) begin
                    nxt_state = S_PH0;
                    nxt_ph = tap_load(2'h0,
                        i_wake_tap_cfg[`CFG_T0], dbl);
                end
            end
            S_PH0: begin
                if (ph_zero) begin
                    nxt_state = S_PH1;
                    nxt_ph = tap_load(2'h1,
                        i_wake_tap_cfg[`CFG_T1], dbl);
                end else begin
                    nxt_ph = ph_ff - 11'h001;
                end
            end
            S_PH1: begin
                if (ph_zero) begin
                    nxt_state = S_PH2;
                    nxt_ph = tap_load(2'h2,
                        i_wake_tap_cfg[`CFG_T2], dbl);
                end else begin
                    nxt_ph = ph_ff - 11'h001;
                end
            end
            S_PH2: begin
                if (ph_zero) begin
                    // A watchdog wake ends in reset, not in resume
                    nxt_state = wdt_wait_ff ? S_AWAKE : S_RESUME;
                end else begin
                    nxt_ph = ph_ff - 11'h001;
                end
            end
            S_RESUME: begin
                if (i_instr_end) begin
                    nxt_state = S_AWAKE;
                end
            end
            default: nxt_state = S_AWAKE;
        endcase
    end

    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            state_ff <= S_AWAKE;
            sleep_ff <= 1'b0;
            mode_ff <= `MODE_STANDBY;
            ph_ff <= 11'h000;
            pg_ff <= 2'h0;
            o_resume <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            ph_ff <= nxt_ph;
            o_resume <= (state_ff == S_PH2) & ph_zero & ~wdt_wait_ff;
            if (state_ff == S_AWAKE && nxt_state == S_ASLEEP) begin
                sleep_ff <= 1'b1;
                if (want_deep) begin
                    mode_ff <= `MODE_DEEP;
                end else if (want_bus) begin
                    mode_ff <= `MODE_BUS;
                end else begin
                    mode_ff <= `MODE_STANDBY;
                end
            end else if (asleep & wake) begin
                sleep_ff <= 1'b0;
            end
            if (state_ff != S_PGOOD) begin
                pg_ff <= 2'h0;
            end else if (ilo_tick) begin
                pg_ff <= pg_ff + 2'h1;
            end
        end
    end

    // Slow oscillator divider, timer, watchdog
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            ilo_ff <= 9'h000;
            timer_ff <= 15'h0000;
            wdt_ff <= 2'h0;
            wdt_wait_ff <= 1'b0;
            o_wdt_reset <= 1'b0;
        end else begin
            o_wdt_reset <= 1'b0;
            if (deep_now || ilo_ff == ILO_DIV - 1) begin
                ilo_ff <= 9'h000;
            end else begin
                ilo_ff <= ilo_ff + 9'h001;
            end
            if (o_wdt_reset | clr_code) begin
                timer_ff <= 15'h0000;
            end else if (st_en) begin
                timer_ff <= st_nxt;
            end
            if (o_wdt_reset | i_wdt_clear_wr) begin
                wdt_ff <= 2'h0;
            end else if (wdt_fire) begin
                wdt_ff <= 2'h0;
                if (asleep | (state_ff != S_AWAKE &
                    state_ff != S_RESUME)) begin
                    wdt_wait_ff <= 1'b1;
                end else begin
                    o_wdt_reset <= 1'b1;
                end
            end else if (roll) begin
                wdt_ff <= wdt_ff + 2'h1;
            end
            if (wdt_wait_ff && state_ff == S_PH2 && ph_zero) begin
                wdt_wait_ff <= 1'b0;
                o_wdt_reset <= 1'b1;
            end
        end
    end

    // Sleep, bus and supply sources are sticky: a set in the clear cycle wins
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            pend_ff <= 6'h00;
            hold_ff <= 1'b0;
        end else begin
            pend_ff[`IRQ_GPIO] <= i_gpio_irq;
            pend_ff[`IRQ_T0] <= i_timer0_irq;
            pend_ff[`IRQ_USB] <= i_usb_irq;
            pend_ff[`IRQ_SLEEP] <= roll |
                (pend_ff[`IRQ_SLEEP] & ~i_sleep_irq_clr);
            pend_ff[`IRQ_I2C] <= i2c_match |
                (pend_ff[`IRQ_I2C] & ~i_i2c_irq_clr);
            pend_ff[`IRQ_LVD] <= (asleep & (mode_ff == `MODE_STANDBY) &
                i_buzz & i_supply_low) |
                (pend_ff[`IRQ_LVD] & ~i_lvd_irq_clr);
            // The boundary ends the hold, so only one boundary is blocked
            if (i_instr_end) begin
                hold_ff <= 1'b0;
            end else if (i_gie_set) begin
                hold_ff <= 1'b1;
            end
        end
    end

    bus_wake_address_watch u_watch (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_listen(asleep & (mode_ff == `MODE_BUS)),
        .i_sleep_req(sleep_ff),
        .i_scl(i_scl),
        .i_sda(i_sda),
        .i_own_addr(i_own_addr),
        .o_match(i2c_match),
        .o_sda_out(o_sda_out),
        .o_sda_oe(o_sda_oe)
    );

    // Service needs the global enable; wake does not
    assign o_irq_take = i_instr_end & i_gie & any_en & ~hold_ff &
        ~i_gie_set & irq_ok;
    assign o_sleep_req = sleep_ff;
    assign o_bus_wake_power = sleep_ff & (mode_ff == `MODE_BUS);
    assign o_slow_osc_pd = sleep_ff & (mode_ff == `MODE_DEEP);
    assign o_slow_clock_run = ~clk_stop & ~deep_now;
    assign o_wake_busy = (state_ff == S_PGOOD) | (state_ff == S_PH0) |
        (state_ff == S_PH1) | (state_ff == S_PH2);
    assign o_sleep_timer = timer_ff;
    assign o_irq_pending = pend_ff;
endmodule

/* core/sleep_wake_map.vh */
// Constants for the sleep and wake controller
`ifndef SLEEP_WAKE_MAP_VH
`define SLEEP_WAKE_MAP_VH
`define CLK_MHZ 10
`define ILO_DIV 312
`define PGOOD_TICKS 3
`define WDT_ROLLS 3
`define WDT_CLR_TIMER 8'h38
`define ST_BITS 15
`define IVL_MASK_0 15'h003F
`define IVL_MASK_1 15'h01FF
`define IVL_MASK_2 15'h0FFF
`define IVL_MASK_3 15'h7FFF
`define T0_US_0 10
`define T0_US_1 14
`define T0_US_2 20
`define T0_US_3 30
`define T1_US_0 3
`define T1_US_1 4
`define T1_US_2 5
`define T1_US_3 10
`define T2_US_0 1
`define T2_US_1 2
`define T2_US_2 5
`define T2_US_3 10
`define CFG_DBL 6
`define CFG_T2 5:4
`define CFG_T1 3:2
`define CFG_T0 1:0
`define IRQ_SLEEP 0
`define IRQ_GPIO 1
`define IRQ_T0 2
`define IRQ_USB 3
`define IRQ_I2C 4
`define IRQ_LVD 5
`define WAKE_STANDBY 6'h2F
`define WAKE_BUS 6'h1F
`define WAKE_DEEP 6'h0A
`define MODE_STANDBY 2'h0
`define MODE_BUS 2'h1
`define MODE_DEEP 2'h2
`endif

/* core/bus_wake_address_watch.v */
// Bus address watcher that runs while the device sleeps
`timescale 1ns/10ps
module bus_wake_address_watch (
    input wire i_ref_clk,
    input wire i_rst,
    input wire i_listen,
    input wire i_sleep_req,
    input wire i_scl,
    input wire i_sda,
    input wire [6:0] i_own_addr,
    output reg o_match,
    output wire o_sda_out,
    output reg o_sda_oe
);
    reg scl_ff;
    reg sda_ff;
    reg slp_ff;
    reg busy_ff;
    reg abort_ff;
    reg [3:0] bit_ff;
    reg [7:0] shift_ff;
    wire start = i_scl & scl_ff & sda_ff & ~i_sda;
    wire stop = i_scl & scl_ff & ~sda_ff & i_sda;
    wire rise = i_scl & ~scl_ff;
    wire fall = ~i_scl & scl_ff;
    wire hit = (shift_ff[7:1] == i_own_addr) & i_listen & ~abort_ff;

    // Released line reads as NACK, so only the ACK is ever driven
    assign o_sda_out = 1'b0;

    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            scl_ff <= 1'b1;
            sda_ff <= 1'b1;
            slp_ff <= 1'b0;
            busy_ff <= 1'b0;
            abort_ff <= 1'b0;
            bit_ff <= 4'hA;
            shift_ff <= 8'h00;
            o_match <= 1'b0;
            o_sda_oe <= 1'b0;
        end else begin
            scl_ff <= i_scl;
            sda_ff <= i_sda;
            slp_ff <= i_sleep_req;
            o_match <= 1'b0;
            if (start) begin
                busy_ff <= 1'b1;
                abort_ff <= 1'b0;
                bit_ff <= 4'h0;
                o_sda_oe <= 1'b0;
            end else if (stop) begin
                busy_ff <= 1'b0;
                abort_ff <= 1'b0;
                bit_ff <= 4'hA;
                o_sda_oe <= 1'b0;
            end else begin
                if (i_sleep_req & ~slp_ff & busy_ff) begin
                    abort_ff <= 1'b1;
                end
                if (rise && bit_ff < 4'h8) begin
                    shift_ff <= {shift_ff[6:0], i_sda};
                    bit_ff <= bit_ff + 4'h1;
                end else if (fall && bit_ff == 4'h8) begin
                    o_sda_oe <= hit;
                    o_match <= hit;
                    bit_ff <= 4'h9;
                end else if (fall && bit_ff == 4'h9) begin
                    o_sda_oe <= 1'b0;
                    bit_ff <= 4'hA;
                end
            end
        end
    end
endmodule

/* dv/sleep_wake_controller_props.sv */
// Port checks for the sleep and wake controller
`timescale 1ns/10ps
module sleep_wake_controller_props (
    input wire i_ref_clk,
    input wire i_rst,
    input wire i_sleep_wr,
    input wire i_bus_wake_en,
    input wire i_usb_en,
    input wire i_crystal_on,
    input wire i_crystal_exists,
    input wire i_slow_osc_off,
    input wire i_debug_mode,
    input wire i_cpu_stop,
    input wire i_wdt_clear_wr,
    input wire [7:0] i_wdt_clear_data,
    input wire [5:0] i_irq_mask,
    input wire i_gie,
    input wire i_gie_set,
    input wire i_instr_end,
    input wire o_sleep_req,
    input wire o_bus_wake_power,
    input wire o_slow_osc_pd,
    input wire o_slow_clock_run,
    input wire o_wake_busy,
    input wire [14:0] o_sleep_timer,
    input wire [5:0] o_irq_pending,
    input wire o_irq_take,
    input wire o_resume,
    input wire o_wdt_reset
);
default clocking @(posedge i_ref_clk); endclocking
default disable iff (i_rst);
property p_refuse;
    i_sleep_wr && !o_sleep_req && (o_irq_pending & i_irq_mask) != 6'h00
    |=> !o_sleep_req;
endproperty
a_refuse: assert property (p_refuse) else $error("sleep set over pend");
property p_bus_power;
    $rose(o_sleep_req) && $past(i_bus_wake_en) |-> o_bus_wake_power;
endproperty
a_bus_power: assert property (p_bus_power) else $error("no bus power");
property p_deep;
    $rose(o_sleep_req) && $past(i_slow_osc_off && !i_bus_wake_en
        && !i_usb_en && !i_crystal_on) |-> o_slow_osc_pd;
endproperty
a_deep: assert property (p_deep) else $error("deep sleep not entered");
property p_no_crystal;
    i_crystal_on && !i_crystal_exists |-> !o_slow_clock_run;
endproperty
a_no_crystal: assert property (p_no_crystal) else $error("slow clock runs");
property p_deep_hold;
    o_slow_osc_pd && $past(o_slow_osc_pd) |-> $stable(o_sleep_timer);
endproperty
a_deep_hold: assert property (p_deep_hold) else $error("timer ran deep");
property p_dbg_hold;
    $past(i_debug_mode && i_cpu_stop && !i_wdt_clear_wr)
    |-> $stable(o_sleep_timer);
endproperty
a_dbg_hold: assert property (p_dbg_hold) else $error("timer ran stop");
property p_clear;
    i_wdt_clear_wr && i_wdt_clear_data == 8'h38 |=> o_sleep_timer == 15'h0000;
endproperty
a_clear: assert property (p_clear) else $error("timer not cleared");
property p_wake_start;
    $fell(o_sleep_req) |-> o_wake_busy;
endproperty
a_wake_start: assert property (p_wake_start) else $error("no wake seq");
property p_wake_end;
    $fell(o_wake_busy) |-> ##[0:1] (o_resume || o_wdt_reset);
endproperty
a_wake_end: assert property (p_wake_end) else $error("no resume");
property p_gie_block;
    i_instr_end && i_gie_set |-> !o_irq_take;
endproperty
a_gie_block: assert property (p_gie_block) else $error("take on set");
property p_take;
    o_irq_take |-> i_gie && i_instr_end && (o_irq_pending & i_irq_mask) != 0;
endproperty
a_take: assert property (p_take) else $error("bad take");
c_bus: cover property ($rose(o_sleep_req) && $past(i_bus_wake_en));
c_wake: cover property ($fell(o_wake_busy));
c_wdt: cover property (o_wdt_reset);
endmodule

/* dv/cpu_core_model.sv */
// Behavioural CPU core: instruction boundaries and global enable
`timescale 1ns/10ps
module cpu_core_model (
    input wire i_ref_clk,
    input wire i_rst,
    input wire i_halt,
    input wire i_resume,
    input wire i_set_gie,
    output reg o_instr_end,
    output reg o_gie,
    output reg o_gie_set
);
reg [1:0] cnt_ff;
reg gie_req_ff;
always @(posedge i_ref_clk) begin
    if (i_rst) begin
        cnt_ff <= 2'h0;
        gie_req_ff <= 1'b0;
        o_instr_end <= 1'b0;
        o_gie <= 1'b0;
        o_gie_set <= 1'b0;
    end else begin
        if (i_resume) begin
            cnt_ff <= 2'h2;
        end else if (!i_halt) begin
            cnt_ff <= cnt_ff + 2'h1;
        end
        // Halted core retires nothing while asleep
        o_instr_end <= !i_halt && cnt_ff == 2'h3;
        if (i_set_gie) begin
            gie_req_ff <= 1'b1;
        end
        if (o_instr_end && gie_req_ff) begin
            gie_req_ff <= 1'b0;
            o_gie <= 1'b1;
            o_gie_set <= 1'b1;
        end else if (o_instr_end) begin
            o_gie_set <= 1'b0;
        end
    end
end
endmodule

/* dv/tb_sleep_wake_controller.sv */
// Self-checking bench for the sleep and wake controller
`timescale 1ns/10ps
`define CHK(nm, e, g) begin \
    checks = checks + 1; \
    if ((g) !== (e)) begin \
        n_mismatch = n_mismatch + 1; \
        $display("BAD %s exp %0h got %0h", nm, e, g); \
    end \
end
module tb_sleep_wake_controller;
localparam INTERNAL_SLOW_OSCILLATOR = 4;
reg clk, rst, sleep_wr, bus_en, usb_en, x_on, x_ex, osc_off, dbg, stop;
reg clr_wr, gpio, t0, usb, buzz, low, slp_clr, lvd_clr, set_gie;
reg took, seen_wdt, scl, sda;
reg [1:0] ivl;
reg [6:0] taps;
reg [7:0] clr_d;
reg [5:0] mask;
reg [14:0] snap;
wire sleep_req, bus_pwr, osc_pd, clk_run, busy, take, resume, wdt, sda_oe;
wire instr_end, gie, gie_set;
wire [14:0] timer;
wire [5:0] pend;
integer n_mismatch, checks, cyc, n, i, len;
sleep_wake_controller #(.ILO_DIV(INTERNAL_SLOW_OSCILLATOR)) DUT (
    .i_ref_clk(clk), .i_rst(rst), .i_sleep_wr(sleep_wr),
    .i_bus_wake_en(bus_en), .i_usb_en(usb_en), .i_crystal_on(x_on),
    .i_crystal_exists(x_ex), .i_slow_osc_off(osc_off),
    .i_crystal_tick(1'b0), .i_interval_sel(ivl), .i_wake_tap_cfg(taps),
    .i_debug_mode(dbg), .i_cpu_stop(stop), .i_wdt_clear_wr(clr_wr),
    .i_wdt_clear_data(clr_d), .i_irq_mask(mask), .i_gpio_irq(gpio),
    .i_timer0_irq(t0), .i_usb_irq(usb), .i_buzz(buzz),
    .i_supply_low(low), .i_sleep_irq_clr(slp_clr),
    .i_i2c_irq_clr(1'b0), .i_lvd_irq_clr(lvd_clr), .i_gie(gie),
    .i_gie_set(gie_set), .i_instr_end(instr_end), .i_scl(scl),
    .i_sda(sda), .i_own_addr(7'h2A), .o_sleep_req(sleep_req),
    .o_bus_wake_power(bus_pwr), .o_slow_osc_pd(osc_pd),
    .o_slow_clock_run(clk_run), .o_wake_busy(busy), .o_sleep_timer(timer),
    .o_irq_pending(pend), .o_irq_take(take), .o_resume(resume),
    .o_wdt_reset(wdt), .o_sda_out(), .o_sda_oe(sda_oe));
cpu_core_model u_cpu (.i_ref_clk(clk), .i_rst(rst),
    .i_halt(sleep_req | busy), .i_resume(resume), .i_set_gie(set_gie),
    .o_instr_end(instr_end), .o_gie(gie), .o_gie_set(gie_set));
initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
end
always @(posedge clk) begin
    cyc = cyc + 1;
    if (take === 1'b1) took <= 1'b1;
    if (cyc == 60000) begin
        n_mismatch = n_mismatch + 1;
        stop_test;
    end
end
task step(input integer k);
    begin
        repeat (k) @(posedge clk);
        #1;
    end
endtask
task go_sleep(input [5:0] m);
    begin
        mask = m;
        sleep_wr = 1'b1;
        step(1);
        sleep_wr = 1'b0;
    end
endtask
task clear_all;
    begin
        clr_wr = 1'b1;
        clr_d = 8'h38;
        slp_clr = 1'b1;
        lvd_clr = 1'b1;
        step(1);
        {clr_wr, slp_clr, lvd_clr} = 3'b000;
        `CHK("timer clear", 15'h0000, timer)
    end
endtask
task wake(output integer len);
    reg r;
    begin
        n = 0;
        len = 0;
        while (busy !== 1'b1 && n < 900) begin
            step(1);
            n = n + 1;
        end
        while (busy === 1'b1 && len < 700) begin
            step(1);
            len = len + 1;
        end
        r = resume;
        seen_wdt = wdt;
        step(1);
        r = r | resume;
        seen_wdt = seen_wdt | wdt;
        `CHK("wake end", 1'b1, r | seen_wdt)
        step(4);
    end
endtask
task i2c_byte(input [7:0] b);
    begin
        for (i = 7; i >= 0; i = i - 1) begin
            scl = 1'b0;
            step(2);
            sda = b[i];
            step(2);
            scl = 1'b1;
            step(2);
        end
        scl = 1'b0;
        step(2);
    end
endtask
task stop_test;
    begin
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end
endtask
initial begin
    {rst, sleep_wr, bus_en, usb_en, x_on, x_ex, osc_off, dbg} = 8'h01 << 7;
    {stop, clr_wr, gpio, t0, usb, buzz, low, slp_clr, lvd_clr} = 9'h000;
    {set_gie, took, cyc, n_mismatch, checks} = 0;
    ivl = 2'h3;
    taps = 7'h00;
    clr_d = 8'h00;
    mask = 6'h00;
    {scl, sda} = 2'b11;
    step(20);
    rst = 1'b0;
    `CHK("timer rst", 15'h0000, timer)
    `CHK("clk run", 1'b1, clk_run)
    go_sleep(6'h02);
    `CHK("standby", 3'h4, {sleep_req, bus_pwr, osc_pd})
    gpio = 1'b1;
    wake(len);
    `CHK("taps plain", 1'b1, len >= 147 && len <= 154)
    gpio = 1'b0;
    step(1);
    taps = 7'h40;
    go_sleep(6'h02);
    gpio = 1'b1;
    wake(len);
    `CHK("taps double", 1'b1, len >= 287 && len <= 294)
    {gpio, taps} = 8'h00;
    $display("test standby done");
    osc_off = 1'b1;
    clear_all;
    go_sleep(6'h0D);
    `CHK("deep", 3'h5, {sleep_req, bus_pwr, osc_pd})
    t0 = 1'b1;
    snap = timer;
    step(30);
    `CHK("deep ignores t0", 1'b1, sleep_req)
    `CHK("deep timer", snap, timer)
    usb = 1'b1;
    wake(len);
    usb = 1'b0;
    go_sleep(6'h0D);
    step(2);
    `CHK("pend blocks", 1'b0, sleep_req)
    {t0, osc_off} = 2'b00;
    step(2);
    $display("test deep done");
    bus_en = 1'b1;
    go_sleep(6'h04);
    `CHK("bus mode", 2'h3, {sleep_req, bus_pwr})
    t0 = 1'b1;
    wake(len);
    {t0, bus_en} = 2'b00;
    step(2);
    go_sleep(6'h20);
    low = 1'b1;
    step(10);
    `CHK("lvd no buzz", 1'b1, sleep_req)
    buzz = 1'b1;
    wake(len);
    `CHK("lvd pend", 1'b1, pend[5])
    {buzz, low} = 2'b00;
    bus_en = 1'b1;
    sda = 1'b0;
    step(2);
    go_sleep(6'h10);
    i2c_byte(8'h54);
    `CHK("sleep nack", 1'b0, sda_oe)
    scl = 1'b1;
    step(2);
    sda = 1'b1;
    step(2);
    sda = 1'b0;
    step(2);
    i2c_byte(8'h54);
    `CHK("address ack", 1'b1, sda_oe)
    wake(len);
    `CHK("i2c pend", 1'b1, pend[4])
    bus_en = 1'b0;
    $display("test wake sources done");
    x_on = 1'b1;
    step(1);
    `CHK("no crystal", 1'b0, clk_run)
    snap = timer;
    step(40);
    `CHK("no crystal timer", snap, timer)
    x_on = 1'b0;
    {dbg, stop} = 2'b11;
    step(1);
    snap = timer;
    step(40);
    `CHK("debug timer", snap, timer)
    {dbg, stop} = 2'b00;
    for (i = 0; i < 3; i = i + 1) begin
        ivl = i[1:0];
        clear_all;
        n = 0;
        while (pend[0] !== 1'b1 && n < 20000) begin
            step(1);
            n = n + 1;
        end
        len = (64 << (3 * i)) * INTERNAL_SLOW_OSCILLATOR;
        `CHK("interval", 1'b1, n >= len - 6 && n <= len + 6)
    end
    ivl = 2'h0;
    clear_all;
    n = 0;
    while (wdt !== 1'b1 && n < 1000) begin
        step(1);
        n = n + 1;
    end
    `CHK("wdt time", 1'b1, n >= 762 && n <= 774)
    step(1);
    `CHK("wdt zero", 1'b1, timer <= 15'h0001)
    clear_all;
    go_sleep(6'h00);
    wake(len);
    `CHK("wdt in sleep", 1'b1, seen_wdt)
    ivl = 2'h3;
    clear_all;
    $display("test timer done");
    gpio = 1'b1;
    mask = 6'h02;
    step(12);
    `CHK("no take", 1'b0, took)
    set_gie = 1'b1;
    step(1);
    set_gie = 1'b0;
    step(12);
    `CHK("take", 1'b1, took)
    $display("test interrupt done");
    stop_test;
end
endmodule
bind sleep_wake_controller sleep_wake_controller_props u_props (
    .i_ref_clk, .i_rst, .i_sleep_wr, .i_bus_wake_en, .i_usb_en,
    .i_crystal_on, .i_crystal_exists, .i_slow_osc_off, .i_debug_mode,
    .i_cpu_stop, .i_wdt_clear_wr, .i_wdt_clear_data, .i_irq_mask, .i_gie,
    .i_gie_set, .i_instr_end, .o_sleep_req, .o_bus_wake_power,
    .o_slow_osc_pd, .o_slow_clock_run, .o_wake_busy, .o_sleep_timer,
    .o_irq_pending, .o_irq_take, .o_resume, .o_wdt_reset);
